// [dv/pci_dev_model.sv]
// Behavioural target model of the accelerator on the bus
`timescale 1ns/1ps
module pci_dev_model (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [31:0] adIn,
   input wire logic [3:0]  cbeIn_n,
   input wire logic        frameIn_n,
   input wire logic        irdyIn_n,
   input wire logic        idsel,
   input wire logic [3:0]  waits,
   input wire logic [7:0]  stopAt,
   input wire logic        claim,
   input wire logic        badPar,
   output logic [31:0]     adDev,
   output logic            parDev,
   output logic            trdy_n,
   output logic            stop_n,
   output logic            devsel_n
);
   logic [31:0] mem [4];
   logic [31:0] adPrev;
   logic [7:0]  phase;
   logic [3:0]  cnt;
   logic [1:0]  idx;
   logic        active, rd, framePrev;
   wire         done = active && !irdyIn_n && !trdy_n;
   // Released lanes show the inverse of the last value
   assign adDev = (active && rd) ? mem[idx] : ~adPrev;
   always_ff @(posedge clk) begin
      adPrev <= adIn;
      framePrev <= frameIn_n;
      parDev <= ^{adIn, cbeIn_n} ^ badPar;
   end
   always_ff @(posedge clk) begin
      if (sys_rst)
         {active, trdy_n, stop_n, devsel_n} <= 4'h7;
      else if (framePrev && !frameIn_n) begin
         if (claim && (idsel || cbeIn_n[3:1] != 3'h5))
            {active, devsel_n, rd, idx, cnt, phase} <= {2'h2, !cbeIn_n[0], adIn[3:2], waits, 8'h01};
      end else if (active) begin
         if (!stop_n && frameIn_n)
            {active, trdy_n, stop_n, devsel_n} <= 4'h7;
         else if (!stop_n)
            trdy_n <= 1'b1;
         else if (done && frameIn_n)
            {active, trdy_n, devsel_n} <= 3'h3;
         else if (done)
            {idx, phase, cnt, trdy_n} <= {idx + 2'h1, phase + 8'h01, waits, 1'b1};
         else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
         else begin
            trdy_n <= 1'b0;
            stop_n <= phase != stopAt;
         end
      end
   end
   always_ff @(posedge clk)
      if (sys_rst)
         mem <= '{default: 32'h0};
      else if (done && !rd)
         for (int b = 0; b < 4; b++)
            if (!cbeIn_n[b]) mem[idx][8*b +: 8] <= adIn[8*b +: 8];
endmodule

// [dv/pci_host_master_bench.sv]
// Self-checking bench for the host bus master against the target model
`timescale 1ns/1ps
module pci_host_master_bench;
   logic clk = 1'b0, sys_rst = 1'b1, reqValid = 1'b0, cfgSelect = 1'b0, deviceReq_n = 1'b1;
   logic claim = 1'b1, badPar = 1'b0, reqReady, wdataReady, rdataValid, doneValid, adOe, cbeOe, parOut, parOe;
   logic frameOut_n, frameOe, irdyOut_n, irdyOe, idsel, deviceGnt_n, trdy_n, stop_n, devsel_n, parDev;
   logic [31:0] rdata, adOut, adDev, got [4];
   logic [3:0]  cbeOut_n, waits = 4'h0;
   logic [7:0]  stopAt = 8'h00;
   pci_host_pkg::request_type req = '0;
   pci_host_pkg::wdata_type   wdata = '0, words [4];
   pci_host_pkg::status_type  status, st;
   int n_mismatch = 0, checked = 0;
   // Bus levels; frame and irdy pulled up when released, released enables read back inverted
   wire [31:0] adBus = adOe ? adOut : adDev;
   wire [3:0]  cbeBus = cbeOe ? cbeOut_n : ~cbeOut_n;
   wire        parBus = parOe ? parOut : parDev;
   wire        frameBus = frameOe ? frameOut_n : 1'b1;
   wire        irdyBus = irdyOe ? irdyOut_n : 1'b1;
   always #5 clk = ~clk;
   pci_host_master i_dut (.clk, .sys_rst, .reqValid, .reqReady, .req, .cfgSelect, .wdata, .wdataReady,
      .rdataValid, .rdata, .doneValid, .status, .adIn(adBus), .adOut, .adOe, .cbeIn_n(cbeBus), .cbeOut_n,
      .cbeOe, .parIn(parBus), .parOut, .parOe, .frameIn_n(frameBus), .frameOut_n, .frameOe, .irdyOut_n,
      .irdyOe, .trdyIn_n(trdy_n), .stopIn_n(stop_n), .devselIn_n(devsel_n), .idsel, .deviceReq_n, .deviceGnt_n);
   pci_dev_model i_dev (.clk, .sys_rst, .adIn(adBus), .cbeIn_n(cbeBus), .frameIn_n(frameBus),
      .irdyIn_n(irdyBus), .idsel, .waits, .stopAt, .claim, .badPar, .adDev, .parDev, .trdy_n, .stop_n, .devsel_n);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d of %0d checks", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [7:0] n, input logic cfg);
      int k = 0, j = 0, t = 0, started = 0;
      req <= '{cmd, addr, n};
      cfgSelect <= cfg;
      wdata <= words[0];
      reqValid <= 1'b1;
      while (1) begin
         @(posedge clk);
         t++;
         if (t > 200) begin
            n_mismatch++;
            end_sim();
         end
         // First word is taken one edge after acceptance, so the next word must follow it
         if (started == 1) begin
            started = 2;
            k = 1;
            wdata <= words[1];
         end
         if (reqValid && reqReady === 1'b1) begin
            reqValid <= 1'b0;
            started = 1;
         end
         if (wdataReady === 1'b1) begin
            k++;
            wdata <= words[k % 4];
         end
         if (rdataValid === 1'b1) begin
            got[j % 4] = rdata;
            j++;
         end
         if (doneValid === 1'b1) begin
            st = status;
            break;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic burstScenario();
      words[0] = '{32'h11223344, 4'hF};
      words[1] = '{32'hAABBCCDD, 4'h5};
      waits <= 4'h2;
      xfer(pci_host_pkg::CMD_MEM_WRITE, 32'h0, 8'h02, 1'b0);
      check(st, 3'h0);
      waits <= 4'h0;
      xfer(pci_host_pkg::CMD_MEM_READ, 32'h0, 8'h02, 1'b0);
      check(got[0], 32'h11223344);
      check(got[1], 32'h00BB00DD);
      check(st, 3'h0);
   endtask
   task automatic stopScenario();
      words[0] = '{32'hCAFEF00D, 4'hF};
      words[1] = '{32'h5A5A5A5A, 4'hF};
      stopAt <= 8'h01;
      xfer(pci_host_pkg::CMD_MEM_WRITE, 32'h8, 8'h03, 1'b0);
      check(st, 3'h2);
      stopAt <= 8'h00;
      xfer(pci_host_pkg::CMD_MEM_READ, 32'h8, 8'h02, 1'b0);
      check(got[0], 32'hCAFEF00D);
      check(got[1], 32'h0);
   endtask
   task automatic selectScenario();
      claim <= 1'b0;
      xfer(pci_host_pkg::CMD_MEM_READ, 32'h0, 8'h01, 1'b0);
      check(st, 3'h4);
      claim <= 1'b1;
      xfer(pci_host_pkg::CMD_CFG_READ, 32'h0, 8'h01, 1'b0);
      check(st, 3'h4);
      words[0] = '{32'h0000BEEF, 4'h3};
      xfer(pci_host_pkg::CMD_CFG_WRITE, 32'hC, 8'h01, 1'b1);
      check(st, 3'h0);
      xfer(pci_host_pkg::CMD_IO_WRITE, 32'h4, 8'h01, 1'b0);
      check(st, 3'h0);
      xfer(pci_host_pkg::CMD_IO_READ, 32'hC, 8'h01, 1'b0);
      check(got[0], 32'h0000BEEF);
   endtask
   task automatic parityScenario();
      badPar <= 1'b1;
      xfer(pci_host_pkg::CMD_MEM_READ, 32'h0, 8'h01, 1'b0);
      check(st, 3'h1);
      badPar <= 1'b0;
   endtask
   task automatic grantScenario();
      deviceReq_n <= 1'b0;
      repeat (2) @(posedge clk);
      check(deviceGnt_n, 1'b0);
      deviceReq_n <= 1'b1;
      repeat (2) @(posedge clk);
      check(deviceGnt_n, 1'b1);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      check(frameOe, 1'b0);
      @(posedge clk);
      sys_rst <= 1'b0;
      burstScenario();
      stopScenario();
      selectScenario();
      parityScenario();
      grantScenario();
      end_sim();
   end
endmodule
bind pci_host_master pci_host_master_props i_props (.clk, .sys_rst, .adOut, .adOe, .cbeOut_n, .cbeOe, .parOut,
   .parOe, .frameOut_n, .frameOe, .irdyOut_n, .irdyOe, .trdyIn_n, .stopIn_n, .devselIn_n, .deviceReq_n,
   .deviceGnt_n, .doneValid);

// [dv/pci_host_master_props.sv]
// Concurrent checks on the host bus master's pins
`timescale 1ns/1ps
module pci_host_master_props (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [31:0] adOut,
   input wire logic        adOe,
   input wire logic [3:0]  cbeOut_n,
   input wire logic        cbeOe,
   input wire logic        parOut,
   input wire logic        parOe,
   input wire logic        frameOut_n,
   input wire logic        frameOe,
   input wire logic        irdyOut_n,
   input wire logic        irdyOe,
   input wire logic        trdyIn_n,
   input wire logic        stopIn_n,
   input wire logic        devselIn_n,
   input wire logic        deviceReq_n,
   input wire logic        deviceGnt_n,
   input wire logic        doneValid
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence addrPhase;
      frameOe && $fell(frameOut_n);
   endsequence
   sequence lastDone;
      irdyOe && frameOut_n && !irdyOut_n && !trdyIn_n;
   endsequence
   reset_release_a: assert property (disable iff (1'b0) sys_rst |=> !(adOe || cbeOe || parOe || frameOe || irdyOe))
      else $error("bus driven after reset");
   line_parity_a: assert property (adOe && cbeOe && !(frameOut_n && irdyOut_n) |=>
      parOe && parOut == ^{$past(adOut), $past(cbeOut_n)}) else $error("bad parity on bus");
   read_turn_a: assert property (addrPhase ##0 !cbeOut_n[0] |=> !adOe)
      else $error("lanes driven in read data phase");
   grant_master_a: assert property (frameOe || irdyOe |-> deviceGnt_n)
      else $error("grant given while mastering");
   grant_request_a: assert property (!deviceGnt_n |-> !deviceReq_n)
      else $error("grant without request");
   final_done_a: assert property (lastDone |=> (irdyOut_n || !irdyOe) ##1 doneValid)
      else $error("final phase not closed");
   wait_hold_a: assert property (irdyOe && !irdyOut_n && trdyIn_n && stopIn_n && !devselIn_n |=>
      !irdyOut_n && $stable(cbeOut_n) && $stable(frameOut_n) && (!adOe || $stable(adOut)))
      else $error("phase changed during wait");
   stop_end_a: assert property (irdyOe && !stopIn_n |=> frameOut_n || !frameOe)
      else $error("frame kept after stop");
endmodule

// [include/pci_host_pkg.sv]
// Constants and carrier types for the host-side bus master that drives the accelerator
package pci_host_pkg;

   localparam logic [3:0] CMD_IO_READ    = 4'h2;
   localparam logic [3:0] CMD_IO_WRITE   = 4'h3;
   localparam logic [3:0] CMD_MEM_READ   = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE  = 4'h7;
   localparam logic [3:0] CMD_CFG_READ   = 4'hA;
   localparam logic [3:0] CMD_CFG_WRITE  = 4'hB;

   // Cycles without a claim before master abort
   localparam int unsigned CLAIM_TIMEOUT = 5;
   localparam int unsigned BURST_LEN_W   = 8;

   // Request from the user side
   typedef struct packed {
      logic [3:0]             command;
      logic [31:0]            address;
      logic [BURST_LEN_W-1:0] count;
   } request_type;

   // Per-phase write data and enables from the user side
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  enables;
   } wdata_type;

   // Completion status to the user side
   typedef struct packed {
      logic aborted;
      logic stopped;
      logic parityError;
   } status_type;

   function automatic logic evenParity(input logic [31:0] ad, input logic [3:0] cbe);
      evenParity = ^{ad, cbe};
   endfunction

   function automatic logic isWrite(input logic [3:0] command);
      isWrite = command[0];
   endfunction

endpackage

// [verilog/pci_host_master.sv]
// Host-side bus master: runs address and data phases against the device's pins
`timescale 1ns/1ps
module pci_host_master #(
   parameter int unsigned TIMEOUT = pci_host_pkg::CLAIM_TIMEOUT
) (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // User side
   input  wire logic                     reqValid,
   output logic                          reqReady,
   input  wire pci_host_pkg::request_type req,
   input  wire logic                     cfgSelect,
   input  wire pci_host_pkg::wdata_type  wdata,
   output logic                          wdataReady,
   output logic                          rdataValid,
   output logic [31:0]                   rdata,
   output logic                          doneValid,
   output pci_host_pkg::status_type      status,
   // Bus pins, active-low ones named with _n
   input  wire logic [31:0]              adIn,
   output logic [31:0]                   adOut,
   output logic                          adOe,
   input  wire logic [3:0]               cbeIn_n,
   output logic [3:0]                    cbeOut_n,
   output logic                          cbeOe,
   input  wire logic                     parIn,
   output logic                          parOut,
   output logic                          parOe,
   input  wire logic                     frameIn_n,
   output logic                          frameOut_n,
   output logic                          frameOe,
   output logic                          irdyOut_n,
   output logic                          irdyOe,
   input  wire logic                     trdyIn_n,
   input  wire logic                     stopIn_n,
   input  wire logic                     devselIn_n,
   output logic                          idsel,
   input  wire logic                     deviceReq_n,
   output logic                          deviceGnt_n
);

   typedef enum logic [2:0] {IDLE, ADDR, DATA, TURN} state_type;

   state_type                          state;
   logic                               writing;
   logic                               claimed;
   logic [pci_host_pkg::BURST_LEN_W-1:0] remaining;
   logic [3:0]                         waitCount;
   logic                               parPending;
   logic                               readCheck;
   logic [31:0]                        lastAd;
   logic [3:0]                         lastCbe;
   logic                               complete;
   logic                               lastPhase;
   logic                               busIdle;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus sampling and phase completion
   assign busIdle    = frameIn_n && devselIn_n;
   assign complete   = (state == DATA) && !irdyOut_n && !trdyIn_n;
   assign lastPhase  = (remaining == 1);
   assign reqReady   = (state == IDLE) && busIdle && !sys_rst;
   assign wdataReady = complete && writing;
   // Bus is given to the device only while the host is not mastering
   assign deviceGnt_n = !(state == IDLE && !reqValid && !deviceReq_n && !sys_rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state     <= IDLE;
         writing   <= 1'b0;
         remaining <= '0;
         waitCount <= '0;
         claimed   <= 1'b0;
         status    <= '0;
         doneValid <= 1'b0;
      end else begin
         doneValid <= 1'b0;
         case (state)
            IDLE: begin
               if (reqValid && busIdle) begin
                  state     <= ADDR;
                  writing   <= pci_host_pkg::isWrite(req.command);
                  remaining <= (req.count == 0) ? pci_host_pkg::BURST_LEN_W'(1) : req.count;
                  status    <= '0;
               end
            end
            ADDR: begin
               state     <= DATA;
               waitCount <= '0;
               claimed   <= 1'b0;
            end
            DATA: begin
               if (!devselIn_n) begin
                  claimed <= 1'b1;
               end
               if (complete) begin
                  remaining <= remaining - 1'b1;
               end
               if (!stopIn_n && (complete || !trdyIn_n || !devselIn_n)) begin
                  status.stopped <= 1'b1;
               end
               if (!claimed && devselIn_n && waitCount == 4'(TIMEOUT)) begin
                  status.aborted <= 1'b1;
                  state          <= TURN;
               end else if ((complete && lastPhase) || (!stopIn_n && (complete || trdyIn_n))) begin
                  state <= TURN;
               end
               if (!claimed) begin
                  waitCount <= waitCount + 1'b1;
               end
            end
            TURN: begin
               state     <= IDLE;
               doneValid <= 1'b1;
            end
            default: state <= IDLE;
         endcase
         // Read parity trails the lanes by one clock
         if (readCheck && parIn != pci_host_pkg::evenParity(lastAd, lastCbe)) begin
            status.parityError <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame, initiator ready, configuration select
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frameOut_n <= 1'b1;
         frameOe    <= 1'b0;
         irdyOut_n  <= 1'b1;
         irdyOe     <= 1'b0;
         idsel      <= 1'b0;
      end else begin
         case (state)
            IDLE: begin
               frameOut_n <= 1'b1;
               irdyOut_n  <= 1'b1;
               frameOe    <= reqValid && busIdle;
               irdyOe     <= reqValid && busIdle;
               if (reqValid && busIdle) begin
                  frameOut_n <= 1'b0;
                  idsel      <= cfgSelect;
               end
            end
            ADDR: begin
               irdyOut_n  <= 1'b0;
               frameOut_n <= (remaining == 1);
            end
            DATA: begin
               if (complete && remaining == 2) begin
                  frameOut_n <= 1'b1;
               end
               if ((complete && lastPhase) || !stopIn_n || (!claimed && devselIn_n && waitCount == 4'(TIMEOUT))) begin
                  frameOut_n <= 1'b1;
                  irdyOut_n  <= 1'b1;
               end
            end
            TURN: begin
               frameOe   <= 1'b0;
               irdyOe    <= 1'b0;
               irdyOut_n <= 1'b1;
               idsel     <= 1'b0;
            end
            default: begin
               frameOe <= 1'b0;
               irdyOe  <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address/data and command/enable lanes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         adOut    <= '0;
         adOe     <= 1'b0;
         cbeOut_n <= 4'hF;
         cbeOe    <= 1'b0;
      end else begin
         case (state)
            IDLE: begin
               adOe  <= reqValid && busIdle;
               cbeOe <= reqValid && busIdle;
               if (reqValid && busIdle) begin
                  adOut    <= req.address;
                  cbeOut_n <= req.command;
               end
            end
            ADDR: begin
               adOe     <= writing;
               adOut    <= wdata.data;
               cbeOut_n <= ~wdata.enables;
            end
            DATA: begin
               if (complete) begin
                  adOut    <= wdata.data;
                  cbeOut_n <= ~wdata.enables;
               end
            end
            TURN: begin
               adOe  <= 1'b0;
               cbeOe <= 1'b0;
            end
            default: begin
               adOe  <= 1'b0;
               cbeOe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Parity drive: one clock behind the lanes it covers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         parOut     <= 1'b0;
         parOe      <= 1'b0;
         parPending <= 1'b0;
         lastAd     <= '0;
         lastCbe    <= 4'hF;
      end else begin
         lastAd  <= adIn;
         lastCbe <= cbeIn_n;
         parOut  <= pci_host_pkg::evenParity(adOut, cbeOut_n);
         // Address phase always, plus the first data clock on reads; every data phase on writes
         parPending <= adOe;
         parOe      <= adOe || (parPending && state != IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data capture and read parity check
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata      <= '0;
         rdataValid <= 1'b0;
         readCheck  <= 1'b0;
      end else begin
         rdataValid <= complete && !writing;
         readCheck  <= complete && !writing;
         if (complete && !writing) begin
            rdata <= adIn;
         end
      end
   end

endmodule
